// File: sim/programmable_sample_delay_control_tb.sv
// Self-checking bench for the sample delay control block
`timescale 1ns/1ps
module programmable_sample_delay_control_tb;
  import psd_pkg::*;
  localparam psd_code_t SHIFT_CODE = 4'hA;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [31:0] wd = 32'h00000000;
  logic [1:0] wpin = 2'h0;
  logic [1:0] fpin = 2'h0;
  logic dready = 1'b0;
  logic go = 1'b0;
  logic [31:0] rdata;
  logic [31:0] r;
  logic pready, perr, e, sv, sr, dv, eq, fden, dsen;
  logic signed [15:0] sd, dd;
  logic signed [4:0] wdel;
  logic [3:0] fcode;
  psd_code_t fp [4] = '{4'h1, 4'h5, 4'hA, 4'hF};
  psd_code_t wc [4] = '{4'h0, 4'h8, 4'hF, 4'h5};
  int num_errors = 0;
  int num_checks = 0;
  int nout = 0;
  int base = 0;
  initial forever #2 clk = ~clk;
  psd_top psd_top_inst (
    .i_core_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr),
    .i_pwdata(wd), .i_pstrb(4'hF), .o_prdata(rdata), .o_pready(pready), .o_pslverr(perr),
    .i_whole_delay_pin_select(wpin), .i_fraction_delay_pin_select(fpin),
    .i_fraction_shift_preset_0(fp[0]), .i_fraction_shift_preset_1(fp[1]),
    .i_fraction_shift_preset_2(fp[2]), .i_fraction_shift_preset_3(fp[3]),
    .i_sample_valid(sv), .i_sample_data(sd), .o_sample_ready(sr), .o_delay_valid(dv), .o_delay_data(dd),
    .i_delay_ready(dready), .o_equaliser_upsampler_clock_select(eq), .o_fraction_delay_unit_enable(fden),
    .o_fraction_downsample_enable(dsen), .o_whole_cycle_delay(wdel), .o_fraction_delay_code(fcode)
  );
  psd_source psd_source_inst (.i_core_clk(clk), .i_rst(rst), .i_go(go), .i_ready(sr), .o_valid(sv), .o_data(sd));
  task conclude;
    if (num_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; holds the request until pready is sampled high
  task apb(input logic w, input logic [15:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    addr <= a;
    wd <= {24'h000000, d};
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      conclude();
    end
    r = rdata;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task wr(input logic [13:0] i, input logic [7:0] d);
    apb(1'b1, {i, 2'h0}, d);
  endtask
  task rd(input logic [13:0] i, input logic [7:0] x);
    apb(1'b0, {i, 2'h0}, 8'h00);
    check(r, {24'h000000, x});
  endtask
  always @(posedge clk) begin
    if (dv === 1'b1 && dready === 1'b1) begin
      check(32'(dd), base > 0 ? 32'(2 * nout - base - SHIFT_CODE) :
            nout >= SHIFT_CODE ? 32'(nout - SHIFT_CODE + 1) : 32'h00000000);
      nout++;
    end
  end
  initial begin
    int i;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 6; i++) rd(14'(IDX_WHOLE_PRESET_0 + i), 8'h00);
    check({27'h0000000, wdel}, 32'h00000018);
    check({25'h0000000, eq, dsen, fden, fcode}, 32'h00000000);
    wr(IDX_WHOLE_PRESET_2, 8'hFF);
    rd(IDX_WHOLE_PRESET_2, 8'h0F);
    wr(IDX_WHOLE_CTRL, 8'hFF);
    rd(IDX_WHOLE_CTRL, 8'h07);
    wr(IDX_FRACTION_CTRL, 8'hFF);
    rd(IDX_FRACTION_CTRL, 8'h3F);
    // Stream through a shifted delay while the receiver stalls
    wr(IDX_WHOLE_CTRL, 8'h00);
    wr(IDX_FRACTION_CTRL, 8'h00);
    wr(IDX_WHOLE_PRESET_0, {4'h0, SHIFT_CODE});
    repeat (3) @(posedge clk);
    go <= 1'b1;
    repeat (12) @(posedge clk);
    check({31'h00000000, sr}, 32'h00000000);
    dready <= 1'b1;
    for (i = 0; i < 300 && nout < 24; i++) @(posedge clk);
    check({31'h00000000, nout >= 24}, 32'h00000001);
    go <= 1'b0;
    repeat (8) @(posedge clk);
    check({31'h00000000, dv}, 32'h00000000);
    // Same ramp with the fractional unit and downsampling on
    base = nout;
    wr(IDX_FRACTION_CTRL, 8'h18);
    go <= 1'b1;
    for (i = 0; i < 300 && nout < base + 8; i++) @(posedge clk);
    check({31'h00000000, nout >= base + 8}, 32'h00000001);
    go <= 1'b0;
    repeat (8) @(posedge clk);
    check({31'h00000000, dv}, 32'h00000000);
    wr(IDX_FRACTION_CTRL, 8'h00);
    // Whole presets by register select, then by pin
    for (i = 0; i < 4; i++) wr(14'(IDX_WHOLE_PRESET_0 + i), {4'h0, wc[i]});
    for (i = 0; i < 4; i++) begin
      wr(IDX_WHOLE_CTRL, 8'(i));
      repeat (3) @(posedge clk);
      check({27'h0000000, wdel}, {27'h0000000, {1'b0, wc[i]} - 5'h08});
    end
    wr(IDX_WHOLE_CTRL, 8'h04);
    wpin <= 2'h2;
    repeat (5) @(posedge clk);
    check({27'h0000000, wdel}, {27'h0000000, {1'b0, wc[2]} - 5'h08});
    apb(1'b0, {IDX_STATUS, 2'h0}, 8'h00);
    check(r, 32'h0000001F);
    // Fraction presets, enables and clock select
    for (i = 0; i < 4; i++) begin
      wr(IDX_FRACTION_CTRL, 8'(8 + i));
      repeat (3) @(posedge clk);
      check({28'h0000000, fcode}, {28'h0000000, fp[i]});
    end
    wr(IDX_FRACTION_CTRL, 8'h3C);
    fpin <= 2'h3;
    repeat (5) @(posedge clk);
    check({25'h0000000, eq, dsen, fden, fcode}, {25'h0000000, 3'h7, fp[3]});
    wr(IDX_FRACTION_CTRL, 8'h00);
    repeat (3) @(posedge clk);
    check({25'h0000000, eq, dsen, fden, fcode}, 32'h00000000);
    // Unmapped and misaligned accesses are refused
    apb(1'b0, 16'h0000, 8'h00);
    check({r[30:0], e}, 32'h00000001);
    apb(1'b1, {IDX_WHOLE_CTRL, 2'h1}, 8'h03);
    check({31'h00000000, e}, 32'h00000001);
    rd(IDX_WHOLE_CTRL, 8'h04);
    conclude();
  end
endmodule

// File: sim/psd_source.sv
// Upstream sample source for the delay block
`timescale 1ns/1ps
module psd_source #(
  parameter int DW = 16
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Handshake
  input wire logic i_go,
  input wire logic i_ready,
  output logic o_valid,
  output logic signed [DW-1:0] o_data
);
  logic signed [DW-1:0] count;
  // Idle data is inverted so no stale word looks valid
  assign o_data = o_valid ? count : ~count;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_valid <= 1'b0;
      count <= DW'(16'h0001);
    end else if (!o_valid || i_ready) begin
      o_valid <= i_go;
      count <= count + DW'(o_valid);
    end
  end
endmodule

// File: sim/psd_top_sva.sv
// Concurrent checks on the ports of the sample delay block
`timescale 1ns/1ps
module psd_top_sva #(
  parameter int DW = 16,
  parameter psd_pkg::psd_code_t WHOLE_PRESET_RESET = 4'h0
) (
  // Clock, reset and bus
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [psd_pkg::APB_AW-1:0] i_paddr,
  input wire logic [psd_pkg::APB_DW-1:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic o_pslverr,
  // Stream and controls
  input wire logic o_delay_valid,
  input wire logic signed [DW-1:0] o_delay_data,
  input wire logic i_delay_ready,
  input wire logic o_equaliser_upsampler_clock_select,
  input wire logic o_fraction_delay_unit_enable,
  input wire logic o_fraction_downsample_enable,
  input wire logic signed [psd_pkg::WHOLE_DELAY_W-1:0] o_whole_cycle_delay,
  input wire logic [psd_pkg::SHIFT_W-1:0] o_fraction_delay_code
);
  import psd_pkg::*;
  logic acc;
  logic fwr;
  assign acc = i_psel && i_penable;
  assign fwr = acc && i_pwrite && i_pstrb[0] && i_paddr == {IDX_FRACTION_CTRL, WORD_ALIGNED};
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  property p_eq; fwr |-> ##2 o_equaliser_upsampler_clock_select == $past(i_pwdata[EQ_CLK_SEL_BIT], 2); endproperty
  a_eq: assert property (p_eq) else $error("clock select wrong");
  property p_ds; fwr |-> ##2 o_fraction_downsample_enable == $past(i_pwdata[DOWNSAMPLE_EN_BIT], 2); endproperty
  a_ds: assert property (p_ds) else $error("downsample enable wrong");
  property p_fd; fwr |-> ##2 o_fraction_delay_unit_enable == $past(i_pwdata[FRACTION_DELAY_UNIT_ENABLE_BIT], 2); endproperty
  a_fd: assert property (p_fd) else $error("fraction enable wrong");
  property p_fd_off; (!o_fraction_delay_unit_enable) [*2] |-> o_fraction_delay_code == 4'h0; endproperty
  a_fd_off: assert property (p_fd_off) else $error("code while disabled");
  property p_rst; $past(i_rst) && !i_rst |-> ##1 o_whole_cycle_delay + 5'sh8 == {1'b0, WHOLE_PRESET_RESET}; endproperty
  a_rst: assert property (p_rst) else $error("whole delay after reset wrong");
  property p_hold; o_delay_valid && !i_delay_ready |=> o_delay_valid && $stable(o_delay_data); endproperty
  a_hold: assert property (p_hold) else $error("output word not held");
  property p_mis; acc && i_paddr[1:0] != WORD_ALIGNED |-> o_pslverr; endproperty
  a_mis: assert property (p_mis) else $error("misaligned access accepted");
  property p_err; o_pslverr |-> acc; endproperty
  a_err: assert property (p_err) else $error("error outside access phase");
  c_fwr: cover property (fwr);
  c_stall: cover property (o_delay_valid && !i_delay_ready ##1 o_delay_valid && i_delay_ready);
  c_err: cover property (o_pslverr);
endmodule
bind psd_top psd_top_sva #(.DW(DW), .WHOLE_PRESET_RESET(WHOLE_PRESET_RESET)) psd_top_sva_inst (
  .i_core_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb, .o_pslverr,
  .o_delay_valid, .o_delay_data, .i_delay_ready, .o_equaliser_upsampler_clock_select,
  .o_fraction_delay_unit_enable, .o_fraction_downsample_enable, .o_whole_cycle_delay, .o_fraction_delay_code
);

// File: src/psd_buffer.sv
// Small valid/ready buffer built from flip-flops
`timescale 1ns/1ps
module psd_buffer #(
  parameter int W = 16,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Filling side
  input wire logic i_valid,
  input wire logic [W-1:0] i_data,
  output logic o_ready,
  // Draining side
  output logic o_valid,
  output logic [W-1:0] o_data,
  input wire logic i_ready
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] store [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic push;
  logic pop;

  assign o_ready = (count != (PW+1)'(DEPTH));
  assign o_valid = (count != '0);
  assign o_data = store[rd_ptr];
  assign push = i_valid & o_ready;
  assign pop = o_valid & i_ready;

  // Pointer wrap for any depth
  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  always_ff @(posedge i_core_clk) begin
    if (push) begin
      store[wr_ptr] <= i_data;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= bump(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= bump(rd_ptr);
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

// File: src/psd_pkg.sv
// Constants, types and helpers shared by the sample delay control block
package psd_pkg;

  // ---------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------
  localparam int APB_AW = 16;
  localparam int APB_DW = 32;
  localparam int REG_INDEX_W = 14;
  localparam int BYTE_OFFSET_W = 2;
  localparam logic [BYTE_OFFSET_W-1:0] WORD_ALIGNED = 2'h0;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [REG_INDEX_W-1:0] IDX_WHOLE_PRESET_0 = 14'h0B01;
  localparam logic [REG_INDEX_W-1:0] IDX_WHOLE_PRESET_1 = 14'h0B02;
  localparam logic [REG_INDEX_W-1:0] IDX_WHOLE_PRESET_2 = 14'h0B03;
  localparam logic [REG_INDEX_W-1:0] IDX_WHOLE_PRESET_3 = 14'h0B04;
  localparam logic [REG_INDEX_W-1:0] IDX_WHOLE_CTRL = 14'h0B05;
  localparam logic [REG_INDEX_W-1:0] IDX_FRACTION_CTRL = 14'h0B06;
  localparam logic [REG_INDEX_W-1:0] IDX_STATUS = 14'h0B10;

  // ---------------------------------------------------------------
  // Field layout
  // ---------------------------------------------------------------
  localparam int SHIFT_W = 4;
  localparam int SEL_W = 2;
  localparam int PRESET_COUNT = 4;
  localparam int SEL_LSB = 0;
  localparam int WHOLE_PIN_EN_BIT = 2;
  localparam int FD_PIN_EN_BIT = 2;
  localparam int FRACTION_DELAY_UNIT_ENABLE_BIT = 3;
  localparam int DOWNSAMPLE_EN_BIT = 4;
  localparam int EQ_CLK_SEL_BIT = 5;
  localparam int STATUS_WHOLE_LSB = 0;
  localparam int STATUS_FRACTION_LSB = 4;
  localparam int STATUS_FD_ACTIVE_BIT = 8;
  localparam int STATUS_PHASE_BIT = 9;
  localparam int FRACTION_LOG2 = 4;
  localparam int WHOLE_DELAY_W = 5;

  // ---------------------------------------------------------------
  // Reset values and codes
  // ---------------------------------------------------------------
  localparam logic [SHIFT_W-1:0] WHOLE_ZERO_CODE = 4'h8;
  localparam logic [SHIFT_W-1:0] WHOLE_SHIFT_RESET = 4'h0;
  localparam logic [SEL_W-1:0] SEL_RESET = 2'h0;
  localparam logic [5:0] FRACTION_CTRL_RESET = 6'h00;
  localparam logic [2:0] WHOLE_CTRL_RESET = 3'h0;

  typedef logic [SHIFT_W-1:0] psd_code_t;
  typedef logic [SEL_W-1:0] psd_sel_t;

  // Picks one of four presets by a two-bit select
  function automatic psd_code_t psd_pick(input psd_sel_t sel, input psd_code_t p0, input psd_code_t p1,
                                         input psd_code_t p2, input psd_code_t p3);
    unique case (sel)
      2'h0: psd_pick = p0;
      2'h1: psd_pick = p1;
      2'h2: psd_pick = p2;
      2'h3: psd_pick = p3;
    endcase
  endfunction

endpackage

// File: src/psd_sync.sv
// Two-stage synchroniser for level inputs
`timescale 1ns/1ps
module psd_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Levels
  input wire logic [W-1:0] i_level,
  output logic [W-1:0] o_level
);
  logic [W-1:0] stage_one;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      stage_one <= '0;
      o_level <= '0;
    end else begin
      stage_one <= i_level;
      o_level <= stage_one;
    end
  end
endmodule

// File: src/psd_top.sv
// Programmable sample delay control: registers, preset selection and delay datapath
`timescale 1ns/1ps
//
// Contract
// - Whole-cycle preset code n means a shift of n minus 8 cycles.
// - Code 8 is the zero-shift code of a whole-cycle preset.
// - Whole pin-enable bit 2 low: register select; high: input pin selects.
// - Whole select codes 0..3 choose presets 0..3; field resets to 0.
// - Fraction control bit 5 picks link-zero (0) or link-one (1) upsampler clock.
// - Fraction control bit 4 enables downsampling, in the datapath only while bit 3 is also set; resets to 0.
// - Fraction control bit 3 enables the fractional unit; resets disabled.
// - Fraction pin-enable bit 2 low: register select; high: input pin selects.
// - Fraction select in bits 1:0, reset 0, chooses the fractional preset.
// - Fraction select codes 0..3 choose fractional presets 0..3.
// - Fractional code n delays by n sixteenths of a cycle; 0 is none.
//
module psd_top #(
  parameter int DW = 16,
  parameter int BUF_DEPTH = 2,
  parameter psd_pkg::psd_code_t WHOLE_PRESET_RESET = psd_pkg::WHOLE_SHIFT_RESET
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [psd_pkg::APB_AW-1:0] i_paddr,
  input wire logic [psd_pkg::APB_DW-1:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [psd_pkg::APB_DW-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Pin preset selects
  input wire logic [psd_pkg::SEL_W-1:0] i_whole_delay_pin_select,
  input wire logic [psd_pkg::SEL_W-1:0] i_fraction_delay_pin_select,
  // Fractional presets held outside this block
  input wire logic [psd_pkg::SHIFT_W-1:0] i_fraction_shift_preset_0,
  input wire logic [psd_pkg::SHIFT_W-1:0] i_fraction_shift_preset_1,
  input wire logic [psd_pkg::SHIFT_W-1:0] i_fraction_shift_preset_2,
  input wire logic [psd_pkg::SHIFT_W-1:0] i_fraction_shift_preset_3,
  // Upstream sample stream
  input wire logic i_sample_valid,
  input wire logic signed [DW-1:0] i_sample_data,
  output logic o_sample_ready,
  // Delayed sample stream
  output logic o_delay_valid,
  output logic signed [DW-1:0] o_delay_data,
  input wire logic i_delay_ready,
  // Control levels
  output logic o_equaliser_upsampler_clock_select,
  output logic o_fraction_delay_unit_enable,
  output logic o_fraction_downsample_enable,
  output logic signed [psd_pkg::WHOLE_DELAY_W-1:0] o_whole_cycle_delay,
  output logic [psd_pkg::SHIFT_W-1:0] o_fraction_delay_code
);
  import psd_pkg::*;

  localparam int TAPS = (1 << SHIFT_W) + 1;
  localparam int PROD_W = DW + 1 + SHIFT_W + 1;

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  psd_code_t whole_shift_preset [PRESET_COUNT];
  logic whole_delay_pin_select_enable;
  psd_sel_t whole_delay_preset_select;
  logic equaliser_upsampler_clock_select;
  logic fraction_downsample_enable;
  logic fraction_delay_unit_enable;
  logic fraction_delay_pin_select_enable;
  psd_sel_t fraction_delay_preset_select;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  logic [REG_INDEX_W-1:0] reg_index;
  logic aligned;
  logic mapped;
  logic setup_phase;
  logic access_phase;
  logic write_strobe;
  logic [7:0] wr_byte;
  logic [APB_DW-1:0] next_prdata;

  assign reg_index = i_paddr[APB_AW-1:BYTE_OFFSET_W];
  assign aligned = (i_paddr[BYTE_OFFSET_W-1:0] == WORD_ALIGNED);
  assign setup_phase = i_psel & ~i_penable;
  assign access_phase = i_psel & i_penable;
  assign wr_byte = i_pwdata[7:0];

  always_comb begin
    unique case (reg_index)
      IDX_WHOLE_PRESET_0, IDX_WHOLE_PRESET_1, IDX_WHOLE_PRESET_2, IDX_WHOLE_PRESET_3,
      IDX_WHOLE_CTRL, IDX_FRACTION_CTRL, IDX_STATUS: mapped = aligned;
      default: mapped = 1'b0;
    endcase
  end

  // Zero-wait answer: the access phase always completes at once
  assign o_pready = access_phase;
  assign o_pslverr = access_phase & ~mapped;
  assign write_strobe = access_phase & i_pwrite & mapped & i_pstrb[0];

  // ---------------------------------------------------------------
  // Whole-cycle presets
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int p = 0; p < PRESET_COUNT; p++) begin
        whole_shift_preset[p] <= WHOLE_PRESET_RESET;
      end
    end else if (write_strobe) begin
      for (int p = 0; p < PRESET_COUNT; p++) begin
        if (reg_index == IDX_WHOLE_PRESET_0 + REG_INDEX_W'(p)) begin
          whole_shift_preset[p] <= wr_byte[SHIFT_W-1:0];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Whole delay control
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      whole_delay_pin_select_enable <= WHOLE_CTRL_RESET[WHOLE_PIN_EN_BIT];
      whole_delay_preset_select <= SEL_RESET;
    end else if (write_strobe && reg_index == IDX_WHOLE_CTRL) begin
      whole_delay_pin_select_enable <= wr_byte[WHOLE_PIN_EN_BIT];
      whole_delay_preset_select <= wr_byte[SEL_LSB +: SEL_W];
    end
  end

  // ---------------------------------------------------------------
  // Fractional delay control
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      equaliser_upsampler_clock_select <= FRACTION_CTRL_RESET[EQ_CLK_SEL_BIT];
      fraction_downsample_enable <= FRACTION_CTRL_RESET[DOWNSAMPLE_EN_BIT];
      fraction_delay_unit_enable <= FRACTION_CTRL_RESET[FRACTION_DELAY_UNIT_ENABLE_BIT];
      fraction_delay_pin_select_enable <= FRACTION_CTRL_RESET[FD_PIN_EN_BIT];
      fraction_delay_preset_select <= SEL_RESET;
    end else if (write_strobe && reg_index == IDX_FRACTION_CTRL) begin
      equaliser_upsampler_clock_select <= wr_byte[EQ_CLK_SEL_BIT];
      fraction_downsample_enable <= wr_byte[DOWNSAMPLE_EN_BIT];
      fraction_delay_unit_enable <= wr_byte[FRACTION_DELAY_UNIT_ENABLE_BIT];
      fraction_delay_pin_select_enable <= wr_byte[FD_PIN_EN_BIT];
      fraction_delay_preset_select <= wr_byte[SEL_LSB +: SEL_W];
    end
  end

  // ---------------------------------------------------------------
  // Pin select synchronisers
  // ---------------------------------------------------------------
  psd_sel_t whole_pin_sync;
  psd_sel_t fraction_pin_sync;

  psd_sync #(
    .W(2 * SEL_W)
  ) psd_sync_inst (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_level({i_whole_delay_pin_select, i_fraction_delay_pin_select}),
    .o_level({whole_pin_sync, fraction_pin_sync})
  );

  // ---------------------------------------------------------------
  // Preset selection
  // ---------------------------------------------------------------
  psd_sel_t whole_active_select;
  psd_sel_t fraction_active_select;
  psd_code_t next_whole_code;
  psd_code_t next_fraction_code;
  psd_code_t whole_code;
  psd_code_t fraction_code;

  assign whole_active_select = whole_delay_pin_select_enable ? whole_pin_sync
                                                             : whole_delay_preset_select;
  assign fraction_active_select = fraction_delay_pin_select_enable ? fraction_pin_sync
                                                                   : fraction_delay_preset_select;
  assign next_whole_code = psd_pick(whole_active_select, whole_shift_preset[0], whole_shift_preset[1],
                                    whole_shift_preset[2], whole_shift_preset[3]);
  assign next_fraction_code = psd_pick(fraction_active_select, i_fraction_shift_preset_0,
                                       i_fraction_shift_preset_1, i_fraction_shift_preset_2,
                                       i_fraction_shift_preset_3);

  // Registered so that the datapath and status read see one stable code per cycle; the control outputs register next_whole_code and next_fraction_code
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      whole_code <= WHOLE_PRESET_RESET;
      fraction_code <= '0;
    end else begin
      whole_code <= next_whole_code;
      fraction_code <= next_fraction_code;
    end
  end

  // ---------------------------------------------------------------
  // Control outputs
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_equaliser_upsampler_clock_select <= FRACTION_CTRL_RESET[EQ_CLK_SEL_BIT];
      o_fraction_delay_unit_enable <= FRACTION_CTRL_RESET[FRACTION_DELAY_UNIT_ENABLE_BIT];
      o_fraction_downsample_enable <= FRACTION_CTRL_RESET[DOWNSAMPLE_EN_BIT];
      o_whole_cycle_delay <= '0;
      o_fraction_delay_code <= '0;
    end else begin
      o_equaliser_upsampler_clock_select <= equaliser_upsampler_clock_select;
      o_fraction_delay_unit_enable <= fraction_delay_unit_enable;
      o_fraction_downsample_enable <= fraction_downsample_enable;
      // Signed shift relative to the zero code
      o_whole_cycle_delay <= $signed({1'b0, next_whole_code})
                             - $signed({1'b0, WHOLE_ZERO_CODE});
      o_fraction_delay_code <= fraction_delay_unit_enable ? next_fraction_code : '0;
    end
  end

  // ---------------------------------------------------------------
  // Sample delay line
  // ---------------------------------------------------------------
  logic signed [DW-1:0] history [TAPS-1];
  logic signed [DW-1:0] taps [TAPS];
  logic buf_in_ready;
  logic accept;
  logic ds_phase;
  logic push;

  assign o_sample_ready = buf_in_ready;
  assign accept = i_sample_valid & buf_in_ready;

  always_comb begin
    taps[0] = i_sample_data;
    for (int t = 1; t < TAPS; t++) begin
      taps[t] = history[t-1];
    end
  end

  // Each accepted sample moves the whole line one place
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int t = 0; t < TAPS - 1; t++) begin
        history[t] <= '0;
      end
    end else if (accept) begin
      for (int t = 0; t < TAPS - 1; t++) begin
        history[t] <= taps[t];
      end
    end
  end

  // ---------------------------------------------------------------
  // Fractional interpolation
  // ---------------------------------------------------------------
  // Code 8 gives the base latency; lower codes advance, higher codes retard
  logic signed [DW-1:0] near_tap;
  logic signed [DW-1:0] far_tap;
  logic signed [DW:0] tap_diff;
  logic signed [PROD_W-1:0] tap_prod;
  logic signed [PROD_W-1:0] tap_step;
  logic signed [DW-1:0] next_sample;

  assign near_tap = taps[whole_code];
  assign far_tap = taps[{1'b0, whole_code} + (SHIFT_W+1)'(1)];
  assign tap_diff = $signed({far_tap[DW-1], far_tap}) - $signed({near_tap[DW-1], near_tap});
  assign tap_prod = PROD_W'(tap_diff * $signed({1'b0, fraction_code}));
  assign tap_step = tap_prod >>> FRACTION_LOG2;

  always_comb begin
    if (fraction_delay_unit_enable) begin
      next_sample = near_tap + tap_step[DW-1:0];
    end else begin
      next_sample = near_tap;
    end
  end

  // ---------------------------------------------------------------
  // Downsampling
  // ---------------------------------------------------------------
  // Keeps every second accepted sample while enabled
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ds_phase <= 1'b0;
    end else if (!(fraction_delay_unit_enable && fraction_downsample_enable)) begin
      ds_phase <= 1'b0;
    end else if (accept) begin
      ds_phase <= ~ds_phase;
    end
  end

  assign push = accept & ~(fraction_delay_unit_enable & fraction_downsample_enable & ds_phase);

  // ---------------------------------------------------------------
  // Output buffer
  // ---------------------------------------------------------------
  logic [DW-1:0] buf_out_data;

  psd_buffer #(
    .W(DW),
    .DEPTH(BUF_DEPTH)
  ) psd_buffer_inst (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_valid(push),
    .i_data(next_sample),
    .o_ready(buf_in_ready),
    .o_valid(o_delay_valid),
    .o_data(buf_out_data),
    .i_ready(i_delay_ready)
  );

  assign o_delay_data = $signed(buf_out_data);

  // ---------------------------------------------------------------
  // Register read
  // ---------------------------------------------------------------
  always_comb begin
    next_prdata = '0;
    unique case (reg_index)
      IDX_WHOLE_PRESET_0: next_prdata[SHIFT_W-1:0] = whole_shift_preset[0];
      IDX_WHOLE_PRESET_1: next_prdata[SHIFT_W-1:0] = whole_shift_preset[1];
      IDX_WHOLE_PRESET_2: next_prdata[SHIFT_W-1:0] = whole_shift_preset[2];
      IDX_WHOLE_PRESET_3: next_prdata[SHIFT_W-1:0] = whole_shift_preset[3];
      IDX_WHOLE_CTRL: begin
        next_prdata[WHOLE_PIN_EN_BIT] = whole_delay_pin_select_enable;
        next_prdata[SEL_LSB +: SEL_W] = whole_delay_preset_select;
      end
      IDX_FRACTION_CTRL: begin
        next_prdata[EQ_CLK_SEL_BIT] = equaliser_upsampler_clock_select;
        next_prdata[DOWNSAMPLE_EN_BIT] = fraction_downsample_enable;
        next_prdata[FRACTION_DELAY_UNIT_ENABLE_BIT] = fraction_delay_unit_enable;
        next_prdata[FD_PIN_EN_BIT] = fraction_delay_pin_select_enable;
        next_prdata[SEL_LSB +: SEL_W] = fraction_delay_preset_select;
      end
      IDX_STATUS: begin
        next_prdata[STATUS_WHOLE_LSB +: SHIFT_W] = whole_code;
        next_prdata[STATUS_FRACTION_LSB +: SHIFT_W] = fraction_code;
        next_prdata[STATUS_FD_ACTIVE_BIT] = fraction_delay_unit_enable;
        next_prdata[STATUS_PHASE_BIT] = ds_phase;
      end
      default: next_prdata = '0;
    endcase
    if (!aligned) begin
      next_prdata = '0;
    end
  end

  // Read data is captured in the setup phase and held through access
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_prdata <= '0;
    end else if (setup_phase) begin
      o_prdata <= next_prdata;
    end
  end
endmodule
